//--- dv/sscd_partner.sv
// host chipset and speaker strap model for the sscd block
`default_nettype none
module sscd_partner (
  // clock, host request and strap pull select
  input wire logic clk,
  input wire logic suspend_req,
  input wire logic pull_low,
  // speaker pin and suspend line
  input wire logic spk_o,
  input wire logic spk_oe,
  output logic pin,
  output logic hw_suspend_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sirq_on = 1'b1;
  logic susp_n_q = 1'b1;
  // strap resistor sets the level once the pin is released
  assign pin = spk_oe ? spk_o : !pull_low;
  assign hw_suspend_n = susp_n_q;
  // serial irq goes off before suspend, back on only after it
  always @(posedge clk)
  begin
    if (suspend_req && sirq_on)
      sirq_on <= 1'b0;
    else if (suspend_req)
      susp_n_q <= 1'b0;
    else if (!susp_n_q)
      susp_n_q <= 1'b1;
    else
      sirq_on <= 1'b1;
  end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the sscd block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, sys_rst = 1, hrst_n = 1, susp = 0, low = 1;
  logic spk_n = 1, pres_n = 1, pin, so, soe, hs_n, crst_n, rom, ins, irst;
  int n_fail = 0, n_tests = 0;
  // 100 ns clock
  always #50 clk = !clk;
  sscd_partner sscd_partner_inst (.clk(clk), .suspend_req(susp),
    .pull_low(low), .spk_o(so), .spk_oe(soe), .pin(pin), .hw_suspend_n(hs_n));
  sscd_top sscd_top_inst (.clk(clk), .sys_rst(sys_rst),
    .host_bus_reset_n(hrst_n), .hw_suspend_n(hs_n),
    .speaker_out_strap_i(pin), .speaker_out_strap_o(so),
    .speaker_out_strap_oe(soe), .card_speaker_n(spk_n),
    .usb_card_present_n(pres_n), .expansion_card_reset_n(crst_n),
    .serial_rom_mode(rom), .card_inserted(ins), .internal_reset(irst));
  // wait edges, then let their updates settle
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t ns: output mismatch", $time);
    end
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // pin must stay released until sampled, then report the strap
  task t_strap(input logic pull);
    @(posedge clk) {sys_rst, low} <= {1'b1, pull};
    cyc(3);
    @(posedge clk) sys_rst <= 1'b0;
    cyc(2);
    chk(soe, 1'b0);
    cyc(8);
    chk(soe, 1'b1);
    chk(rom, pull);
    $display("strap test done");
  endtask
  task t_audio;
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clk) spk_n <= v[0];
      cyc(2);
      chk(pin, !v[0]);
    end
    $display("audio test done");
  endtask
  // card reset is held ten cycles after insertion
  task t_card;
    @(posedge clk) pres_n <= 1'b0;
    cyc(3);
    chk(ins, 1'b1);
    cyc(9);
    chk(crst_n, 1'b0);
    cyc(1);
    chk(crst_n, 1'b1);
    @(posedge clk) pres_n <= 1'b1;
    cyc(4);
    chk(ins, 1'b0);
    chk(crst_n, 1'b0);
    $display("card test done");
  endtask
  // card pulled during the hold, then host reset while running
  task t_cut;
    @(posedge clk) pres_n <= 1'b0;
    cyc(6);
    @(posedge clk) pres_n <= 1'b1;
    cyc(12);
    chk(crst_n, 1'b0);
    chk(ins, 1'b0);
    @(posedge clk) pres_n <= 1'b0;
    cyc(14);
    chk(crst_n, 1'b1);
    @(posedge clk) hrst_n <= 1'b0;
    cyc(2);
    chk(crst_n, 1'b0);
    chk(ins, 1'b1);
    @(posedge clk) hrst_n <= 1'b1;
    cyc(11);
    chk(crst_n, 1'b0);
    cyc(1);
    chk(crst_n, 1'b1);
    @(posedge clk) pres_n <= 1'b1;
    cyc(4);
    chk(crst_n, 1'b0);
    $display("card cut test done");
  endtask
  // host reset is obeyed, then ignored while suspended
  task t_susp;
    @(posedge clk) hrst_n <= 1'b0;
    cyc(3);
    chk(irst, 1'b1);
    @(posedge clk) {hrst_n, susp} <= 2'b11;
    cyc(7);
    chk(irst, 1'b0);
    @(posedge clk) hrst_n <= 1'b0;
    cyc(4);
    chk(irst, 1'b0);
    @(posedge clk) susp <= 1'b0;
    cyc(6);
    chk(irst, 1'b1);
    @(posedge clk) hrst_n <= 1'b1;
    $display("suspend test done");
  endtask
  initial
  begin
    t_strap(1'b1);
    t_audio;
    t_card;
    t_cut;
    t_susp;
    t_strap(1'b0);
    complete_run;
  end
  // watchdog, well past the expected run
  initial
  begin
    #200000;
    n_fail++;
    complete_run;
  end
endmodule
`default_nettype wire

//--- hdl/sscd_pkg.sv
// shared constants for the suspend, strap and card detect block
`default_nettype none
package sscd_pkg;
  // strap capture happens a fixed number of cycles after reset release
  localparam int unsigned STRAP_DELAY_NS = 400;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned STRAP_CYC_RAW = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;
  localparam logic [3:0] STRAP_CYC = 4'(STRAP_CYC_RAW < 1 ? 1 : STRAP_CYC_RAW);
  // card reset held this many cycles after the card appears
  localparam int unsigned CARD_RST_NS = 1000;
  localparam int unsigned CARD_RST_RAW = (CARD_RST_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
  localparam logic [3:0] CARD_RST_CYC = 4'(CARD_RST_RAW);
  localparam logic [1:0] SYNC_RST_VAL = 2'h3; // low-active inputs idle high
  typedef enum logic [1:0] {SSCD_CARD_EMPTY, SSCD_CARD_RESET,
                            SSCD_CARD_RUN} sscd_card_state_t;
endpackage
`default_nettype wire

//--- hdl/sscd_top.sv
// suspend masking, speaker strap and usb card detect/reset logic
`default_nettype none
// Contract
// - suspend asserted masks the host bus reset
// - speaker pin low at reset selects rom
// - speaker pin carries card audio normally
// - monitor low-active usb card presence input
// - drive low-active reset to usb card
module sscd_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host side
  input wire logic host_bus_reset_n,
  input wire logic hw_suspend_n,
  // speaker pin, two-way
  input wire logic speaker_out_strap_i,
  output logic speaker_out_strap_o,
  output logic speaker_out_strap_oe,
  input wire logic card_speaker_n,
  // usb card socket
  input wire logic usb_card_present_n,
  output logic expansion_card_reset_n,
  // status
  output logic serial_rom_mode,
  output logic card_inserted,
  output logic internal_reset
);
  import sscd_pkg::*;

  logic [1:0] susp_sync_q;
  logic [1:0] pres_sync_q;
  logic suspended;
  logic strap_done_q;
  logic [3:0] strap_cnt_q;
  logic rom_mode_q;
  logic [3:0] card_cnt_q;
  logic card_rst_n_q;
  logic spk_q;
  logic int_rst_q;
  sscd_card_state_t card_state_q;

  // two-flop synchronisers, second stage only is used
  // reset to idle high, so no false suspend or insertion follows reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      susp_sync_q <= SYNC_RST_VAL;
      pres_sync_q <= SYNC_RST_VAL;
    end
    else
    begin
      susp_sync_q <= {susp_sync_q[0], hw_suspend_n};
      pres_sync_q <= {pres_sync_q[0], usb_card_present_n};
    end
  end

  assign suspended = ~susp_sync_q[1];

  // host reset is ignored while suspended so the host io supply may drop;
  // the host must order serial irq around suspend, we do not check it;
  // no serial irq input reaches this block, so the host model keeps it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      int_rst_q <= 1'b1;
    else if (!suspended)
      int_rst_q <= ~host_bus_reset_n;
  end

  assign internal_reset = int_rst_q;

  // strap window: pin released for a few cycles, then sampled once
  // a host reset restarts the window, so the strap is taken again
  always_ff @(posedge clk)
  begin
    if (sys_rst || int_rst_q)
    begin
      strap_cnt_q <= 4'h0;
      strap_done_q <= 1'b0;
      rom_mode_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      strap_cnt_q <= strap_cnt_q + 4'h1;
      if (strap_cnt_q == STRAP_CYC)
      begin
        strap_done_q <= 1'b1;
        rom_mode_q <= ~speaker_out_strap_i;
      end
    end
  end

  assign serial_rom_mode = rom_mode_q;

  // audio output registered; card line is low-active, pin is true level
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      spk_q <= 1'b0;
    else
      spk_q <= ~card_speaker_n;
  end

  // pin only driven after the strap is taken, else the pull-down loses
  assign speaker_out_strap_o = spk_q;
  assign speaker_out_strap_oe = strap_done_q;

  // card presence and reset sequencing
  always_ff @(posedge clk)
  begin
    if (sys_rst || int_rst_q)
    begin
      card_state_q <= SSCD_CARD_EMPTY;
      card_cnt_q <= 4'h0;
      card_rst_n_q <= 1'b0;
    end
    else
    begin
      unique case (card_state_q)
        SSCD_CARD_EMPTY:
        begin
          card_rst_n_q <= 1'b0;
          card_cnt_q <= 4'h0;
          if (!pres_sync_q[1])
            card_state_q <= SSCD_CARD_RESET;
        end
        SSCD_CARD_RESET:
        begin
          card_cnt_q <= card_cnt_q + 4'h1;
          if (pres_sync_q[1])
            card_state_q <= SSCD_CARD_EMPTY;
          else if (card_cnt_q == CARD_RST_CYC - 4'h1)
          begin
            card_state_q <= SSCD_CARD_RUN;
            card_rst_n_q <= 1'b1;
          end
        end
        SSCD_CARD_RUN:
        begin
          if (pres_sync_q[1]) // removal asserts reset at once
          begin
            card_state_q <= SSCD_CARD_EMPTY;
            card_rst_n_q <= 1'b0;
          end
        end
        // stray code falls back to empty; card reset keeps its value until empty drives it low
        default:
          card_state_q <= SSCD_CARD_EMPTY;
      endcase
    end
  end

  assign expansion_card_reset_n = card_rst_n_q;
  assign card_inserted = ~pres_sync_q[1];

  // assertions: host reset masking under suspend
  AST_SUSP_MASK: assert property (@(posedge clk)
    disable iff (sys_rst)
    suspended |=> $stable(int_rst_q))
    else $error("internal reset moved while suspended");
  // sampled sys_rst keeps the release edge out of the check
  AST_RST_FOLLOW: assert property (@(posedge clk)
    disable iff (sys_rst)
    !suspended && !sys_rst |=> int_rst_q == !$past(host_bus_reset_n))
    else $error("internal reset did not follow host reset");
  AST_SUSP_SYNC: assert property (@(posedge clk)
    disable iff (sys_rst)
    $fell(hw_suspend_n) ##1 !hw_suspend_n |=> suspended)
    else $error("suspend not seen two cycles later");
  // strap and speaker pin
  AST_STRAP_OE: assert property (@(posedge clk)
    disable iff (sys_rst)
    $rose(strap_done_q) |-> rom_mode_q == !$past(speaker_out_strap_i))
    else $error("strap value wrong");
  AST_ROM_HOLD: assert property (@(posedge clk)
    disable iff (sys_rst)
    strap_done_q && !int_rst_q |=> $stable(serial_rom_mode))
    else $error("strap value changed without a reset");
  AST_SPK: assert property (@(posedge clk)
    disable iff (sys_rst)
    strap_done_q |-> ##1 speaker_out_strap_o == !$past(card_speaker_n))
    else $error("speaker output does not follow card audio");
  // card presence and reset
  AST_PRES: assert property (@(posedge clk)
    disable iff (sys_rst)
    $fell(usb_card_present_n) ##1 !usb_card_present_n |=> card_inserted)
    else $error("presence not reported");
  AST_PRES_GONE: assert property (@(posedge clk)
    disable iff (sys_rst)
    $rose(usb_card_present_n) ##1 usb_card_present_n |=> !card_inserted)
    else $error("removal not reported");
  AST_CARD_RST: assert property (@(posedge clk)
    disable iff (sys_rst || int_rst_q)
    $rose(expansion_card_reset_n) |-> $past(card_inserted, 10))
    else $error("card reset released too early");
  AST_CARD_HOLD: assert property (@(posedge clk)
    disable iff (sys_rst)
    $rose(card_inserted) |=> !expansion_card_reset_n [*8])
    else $error("card reset released during the hold");
  AST_CARD_GONE: assert property (@(posedge clk)
    disable iff (sys_rst)
    !card_inserted |=> !expansion_card_reset_n)
    else $error("card reset not asserted without card");
  AST_HOST_RST_CARD: assert property (@(posedge clk)
    disable iff (sys_rst)
    internal_reset |=> !expansion_card_reset_n)
    else $error("card reset not asserted under host reset");
  // main scenarios
  COV_SUSPEND: cover property (@(posedge clk) disable iff (sys_rst)
    suspended && !host_bus_reset_n);
  COV_ROM: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(strap_done_q) && rom_mode_q);
  COV_CARD_RUN: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(expansion_card_reset_n));
  COV_CARD_CUT: cover property (@(posedge clk) disable iff (sys_rst)
    card_state_q == SSCD_CARD_RESET && !card_inserted);
  COV_HOST_RST_CARD: cover property (@(posedge clk) disable iff (sys_rst)
    internal_reset && card_inserted);
endmodule
`default_nettype wire
